// File: dqc_adc_model.sv
/*
  Converter stand-in for the card control bench: answers each start
  pulse with one done pulse carrying a value, after a chosen delay.
  Assumes the control block's clock and its synchronous active-high reset.
*/
`default_nettype none
module dqc_adc_model (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic [3:0] delay_in,
  input wire logic [11:0] value_in,
  output logic done_out,
  output logic [11:0] value_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_r; // Conversion in flight
  logic [3:0] cnt_r; // Cycles left before done
  // Outside the done cycle the bus carries junk, so a stale value cannot pass
  assign value_out = done_out ? value_in : ~value_in;
  // Count the delay down, then pulse done for one cycle
  always_ff @(posedge core_clk_in)
  begin
    done_out <= 1'b0;
    if (srst_in)
      busy_r <= 1'b0;
    else if (start_in && !busy_r)
    begin
      busy_r <= 1'b1;
      cnt_r <= delay_in;
    end
    else if (busy_r && cnt_r == 4'h0)
    begin
      busy_r <= 1'b0;
      done_out <= 1'b1;
    end
    else if (busy_r)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule
`default_nettype wire

// File: dqc_card_ctrl.sv
/*
  Control logic of the acquisition card: digital ports, two D/A codes,
  channel and range selection, trigger/transfer mode and channel autoscan.
  Assumes the host writes through one-cycle strobes, the analog converter
  answers each start with a done pulse and its 12-bit value, and all pins
  are synchronous to core_clk_in.
*/
//
// Behaviour
// - Sixteen input lines read as one word
// - Bit read returns selected input line only
// - Output port follows host written word
// - Two independent twelve bit D/A registers
// - D/A writes keep low twelve bits only
// - Channel range 0-15 single, 0-7 differential
// - Channel register resets to channel zero
// - Range selects gain and polarity
// - Range resets to gain one bipolar
// - Mode picks one of six trigger/transfer pairs
// - Mode resets to software trigger, polling
// - Bus-master modes enable bus-master transfer
// - Interrupt modes flag each finished conversion
// - Autoscan counts down to zero, reloads start
// - Without autoscan channel stays fixed
// - Software trigger pulses one conversion start
// - Ready bit low while result available
// - Result word: channel low, value high
`default_nettype none
module dqc_card_ctrl
  import dqc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [15:0] di_pins_in,
  input wire logic [3:0] di_bit_sel_in,
  input wire logic do_wr_in,
  input wire logic [15:0] do_data_in,
  input wire logic dac_wr_in,
  input wire logic dac_sel_in,
  input wire logic [15:0] dac_data_in,
  input wire logic diff_mode_in,
  input wire logic ch_wr_in,
  input wire logic [3:0] ch_data_in,
  input wire logic range_wr_in,
  input wire dqc_range_t range_data_in,
  input wire logic mode_wr_in,
  input wire logic [2:0] mode_data_in,
  input wire logic autoscan_in,
  input wire logic soft_trig_in,
  input wire logic timer_tick_in,
  input wire logic ext_trig_in,
  input wire logic adc_done_in,
  input wire logic [11:0] adc_value_in,
  input wire logic result_rd_in,
  output logic [15:0] di_word_out,
  output logic di_bit_out,
  output logic [15:0] do_pins_out,
  output logic [11:0] dac_first_channel_out,
  output logic [11:0] dac_second_channel_out,
  output logic [3:0] ch_reg_out,
  output logic [3:0] adc_mux_out,
  output dqc_range_t range_out,
  output logic [2:0] mode_out,
  output logic mode_err_out,
  output logic adc_start_out,
  output logic ready_n_out,
  output dqc_result_t result_out,
  output logic conv_irq_out,
  output logic bm_enable_out,
  output logic bm_push_out
);
  // Whole state of the control block
  typedef struct packed {
    logic [15:0] di_word;
    logic di_bit;
    logic [15:0] do_pins;
    logic [3:0] ch;
    logic [3:0] scan;
    dqc_range_t range;
    logic [2:0] mode;
    logic mode_err;
    dqc_state_t state;
    logic start;
    logic ready_n;
    dqc_result_t result;
    logic irq;
    logic bm_en;
    logic bm_push;
  } dqc_st_t;
  dqc_st_t st_r;
  dqc_st_t st_nxt;
  logic trig; // Trigger chosen by current mode
  logic [3:0] ch_lim; // Highest legal channel for wiring

  // Mode decode used in several places
  function automatic logic mode_is_bm(input logic [2:0] m);
    return (m == DQC_MODE_TMR_BM) || (m == DQC_MODE_EXT_BM);
  endfunction
  function automatic logic mode_is_irq(input logic [2:0] m);
    return (m == DQC_MODE_TMR_IRQ) || (m == DQC_MODE_EXT_IRQ);
  endfunction

  // D/A codes live in their own store; upper bits dropped here
  dqc_dac_mem #(.W(DQC_DAC_W)) u_dac (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .wr_en_in(dac_wr_in),
    .wr_sel_in(dac_sel_in),
    .wr_data_in(dac_data_in[11:0]),
    .first_out(dac_first_channel_out),
    .second_out(dac_second_channel_out)
  );

  // Trigger source selection by mode
  always_comb
  begin
    case (st_r.mode)
      DQC_MODE_SW_POLL: trig = soft_trig_in;
      DQC_MODE_TMR_IRQ, DQC_MODE_TMR_BM: trig = timer_tick_in;
      DQC_MODE_EXT_POLL, DQC_MODE_EXT_IRQ, DQC_MODE_EXT_BM: trig = ext_trig_in;
      default: trig = 1'b0;
    endcase
    ch_lim = diff_mode_in ? DQC_CH_MAX_DIFF : DQC_CH_MAX_SE;
  end

  // Next-state logic for every register of the block
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.bm_push = 1'b0;
    st_nxt.di_word = di_pins_in;
    st_nxt.di_bit = di_pins_in[di_bit_sel_in];
    if (do_wr_in)
    begin
      st_nxt.do_pins = do_data_in;
    end
    // Out-of-range channels are clipped; host is expected not to send them
    if (ch_wr_in)
    begin
      st_nxt.ch = (ch_data_in > ch_lim) ? ch_lim : ch_data_in;
      st_nxt.scan = st_nxt.ch;
    end
    if (range_wr_in)
    begin
      st_nxt.range = range_data_in;
    end
    // Reserved mode codes leave the mode alone and raise a sticky error
    if (mode_wr_in)
    begin
      if (mode_data_in > DQC_MODE_EXT_BM)
      begin
        st_nxt.mode_err = 1'b1;
      end
      else
      begin
        st_nxt.mode = mode_data_in;
        st_nxt.mode_err = 1'b0;
      end
    end
    st_nxt.bm_en = mode_is_bm(st_nxt.mode);
    if (!autoscan_in && !ch_wr_in)
    begin
      st_nxt.scan = st_r.ch;
    end
    // Reading the result releases the ready bit and the interrupt
    if (result_rd_in)
    begin
      st_nxt.ready_n = 1'b1;
      st_nxt.irq = 1'b0;
    end
    case (st_r.state)
      DQC_IDLE:
      begin
        if (trig)
        begin
          st_nxt.start = 1'b1;
          st_nxt.state = DQC_CONV;
        end
      end
      DQC_CONV:
      begin
        // Completion beats a same-cycle read so no result is lost
        if (adc_done_in)
        begin
          st_nxt.state = DQC_IDLE;
          st_nxt.result.value = adc_value_in;
          st_nxt.result.chan = st_r.scan;
          st_nxt.ready_n = 1'b0;
          st_nxt.irq = mode_is_irq(st_r.mode);
          st_nxt.bm_push = st_r.bm_en;
          if (autoscan_in && !ch_wr_in)
          begin
            st_nxt.scan = (st_r.scan == 4'h0) ? st_r.ch : st_r.scan - 4'h1;
          end
        end
      end
      default: st_nxt.state = DQC_IDLE;
    endcase
  end

  // Register the state; reset gives channel 0, +/-5 V, soft/poll mode
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      st_r <= '0;
      st_r.do_pins <= DQC_DO_RST;
      st_r.ch <= DQC_CH_RST;
      st_r.scan <= DQC_CH_RST;
      st_r.range <= DQC_RANGE_RST;
      st_r.mode <= DQC_MODE_RST;
      st_r.state <= DQC_IDLE;
      st_r.ready_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign di_word_out = st_r.di_word;
  assign di_bit_out = st_r.di_bit;
  assign do_pins_out = st_r.do_pins;
  assign ch_reg_out = st_r.ch;
  assign adc_mux_out = st_r.scan;
  assign range_out = st_r.range;
  assign mode_out = st_r.mode;
  assign mode_err_out = st_r.mode_err;
  assign adc_start_out = st_r.start;
  assign ready_n_out = st_r.ready_n;
  assign result_out = st_r.result;
  assign conv_irq_out = st_r.irq;
  assign bm_enable_out = st_r.bm_en;
  assign bm_push_out = st_r.bm_push;

  // Checks beside the logic
  sequence s_done_in_conv;
    (st_r.state == DQC_CONV) && adc_done_in;
  endsequence
  // The cycle after reset shows the cleared register, not a sampled pin, so skip it
  a_di_bit_pick: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !$past(srst_in) |-> di_bit_out == $past(di_pins_in[di_bit_sel_in]))
    else $error("bit read wrong");
  a_do_follow: assert property (@(posedge core_clk_in) disable iff (srst_in)
    do_wr_in |=> do_pins_out == $past(do_data_in)) else $error("output port wrong");
  a_dac_trunc: assert property (@(posedge core_clk_in) disable iff (srst_in)
    dac_wr_in && !dac_sel_in |=> dac_first_channel_out == $past(dac_data_in[11:0]))
    else $error("dac code wrong");
  a_ch_limit: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ch_wr_in && diff_mode_in |=> ch_reg_out <= DQC_CH_MAX_DIFF) else $error("channel range");
  a_mode_bad: assert property (@(posedge core_clk_in) disable iff (srst_in)
    mode_wr_in && mode_data_in > DQC_MODE_EXT_BM |=> $stable(mode_out) && mode_err_out)
    else $error("bad mode accepted");
  a_start_once: assert property (@(posedge core_clk_in) disable iff (srst_in)
    adc_start_out |=> !adc_start_out) else $error("start not single");
  a_ready_low: assert property (@(posedge core_clk_in) disable iff (srst_in)
    s_done_in_conv |=> !ready_n_out && result_out.value == $past(adc_value_in))
    else $error("ready not low");
  a_scan_wrap: assert property (@(posedge core_clk_in) disable iff (srst_in)
    s_done_in_conv ##0 (autoscan_in && !ch_wr_in && adc_mux_out == 4'h0)
    |=> adc_mux_out == ch_reg_out) else $error("scan no reload");
  a_scan_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !autoscan_in && !ch_wr_in |=> adc_mux_out == $past(ch_reg_out)) else $error("scan moved");
  a_irq_mode: assert property (@(posedge core_clk_in) disable iff (srst_in)
    conv_irq_out |-> mode_is_irq($past(mode_out)) || !$rose(conv_irq_out))
    else $error("irq in wrong mode");
endmodule
`default_nettype wire

// File: dqc_card_ctrl_bench.sv
/*
  Self-checking bench for the card control block with a converter model.
  Assumes strobes are one-cycle pulses taken at the rising clock edge.
*/
`default_nettype none
module dqc_card_ctrl_bench
  import dqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, diff = 1'b0, auto = 1'b0, dac_sel = 1'b0;
  logic [8:0] stb = '0; // do,dac,ch,range,mode,soft,timer,ext,read
  logic [15:0] di_pins = '0, do_data = '0, dac_data = '0;
  logic [3:0] di_sel = '0, ch_data = '0, dly = '0;
  logic [2:0] mode_data = '0;
  dqc_range_t range_data = DQC_RANGE_RST;
  logic [11:0] aset = '0, aval, dac1, dac2;
  logic done, di_bit, mode_err, start, ready_n, irq, bm_en, bm_push;
  logic [15:0] di_word, do_pins;
  logic [3:0] ch_reg, mux;
  logic [2:0] mode_o;
  dqc_range_t range_o;
  dqc_result_t result;
  int miscompares = 0, check_count = 0, cyc = 0;
  // Clock of 100 ns period
  always #50 clk = ~clk;
  dqc_card_ctrl dqc_card_ctrl_inst (.core_clk_in(clk), .srst_in(srst),
    .di_pins_in(di_pins), .di_bit_sel_in(di_sel), .do_wr_in(stb[0]),
    .do_data_in(do_data), .dac_wr_in(stb[1]), .dac_sel_in(dac_sel),
    .dac_data_in(dac_data), .diff_mode_in(diff), .ch_wr_in(stb[2]),
    .ch_data_in(ch_data), .range_wr_in(stb[3]), .range_data_in(range_data),
    .mode_wr_in(stb[4]), .mode_data_in(mode_data), .autoscan_in(auto),
    .soft_trig_in(stb[5]), .timer_tick_in(stb[6]), .ext_trig_in(stb[7]),
    .adc_done_in(done), .adc_value_in(aval), .result_rd_in(stb[8]),
    .di_word_out(di_word), .di_bit_out(di_bit), .do_pins_out(do_pins),
    .dac_first_channel_out(dac1), .dac_second_channel_out(dac2),
    .ch_reg_out(ch_reg), .adc_mux_out(mux), .range_out(range_o), .mode_out(mode_o),
    .mode_err_out(mode_err), .adc_start_out(start), .ready_n_out(ready_n),
    .result_out(result), .conv_irq_out(irq), .bm_enable_out(bm_en), .bm_push_out(bm_push));
  dqc_adc_model dqc_adc_model_inst (.core_clk_in(clk), .srst_in(srst), .start_in(start),
    .delay_in(dly), .value_in(aset), .done_out(done), .value_out(aval));
  // Verdict and end of run, shared by the main flow and the watchdog
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One-cycle strobe; returns just after the edge that took it
  task automatic pulse(input int k);
    @(posedge clk) stb[k] <= 1'b1;
    @(posedge clk) stb[k] <= 1'b0;
    #1;
  endtask
  // Trigger one conversion, poll ready low, read and release it
  task automatic conv(input int k, input logic [11:0] v, input logic [3:0] ch,
                      input logic ex_irq);
    int n;
    @(posedge clk) aset <= v;
    #1;
    chk(mux, ch, "mux");
    pulse(k);
    n = 0;
    while (ready_n !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(ready_n, 0, "ready");
    chk(result, {v, ch}, "result");
    chk(irq, ex_irq, "irq");
    // Push stands only in the cycle ready falls, which is where the poll stops
    chk(bm_push, mode_data == DQC_MODE_TMR_BM || mode_data == DQC_MODE_EXT_BM,
        "bm push");
    pulse(8);
    chk(ready_n, 1, "released");
  endtask
  // Watchdog: a hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(ch_reg, 0, "ch reset");
    chk(range_o, DQC_RANGE_RST, "range reset");
    chk(mode_o, DQC_MODE_SW_POLL, "mode reset");
    @(posedge clk) di_pins <= 16'ha5c3;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk) di_sel <= 4'(i);
      repeat (2) @(posedge clk);
      #1;
      chk(di_bit, di_pins[i], "di bit");
    end
    chk(di_word, 16'ha5c3, "di word");
    @(posedge clk) do_data <= 16'h3c5a;
    pulse(0);
    chk(do_pins, 16'h3c5a, "do");
    @(posedge clk) dac_data <= 16'hf123;
    pulse(1);
    @(posedge clk) {dac_sel, dac_data} <= {1'b1, 16'h0fff};
    pulse(1);
    @(posedge clk);
    #1;
    chk(dac1, 12'h123, "dac first");
    chk(dac2, 12'hfff, "dac second");
    for (int g = 0; g < 10; g++)
    begin
      @(posedge clk) range_data <= '{gain: dqc_gain_t'(g / 2), unipolar: g[0]};
      pulse(3);
      chk(range_o, {3'(g / 2), g[0]}, "range");
    end
    for (int m = 0; m < 8; m++)
    begin
      @(posedge clk) mode_data <= 3'(m);
      pulse(4);
      chk(mode_o, (m > 5) ? 3'h5 : 3'(m), "mode");
      chk(mode_err, m > 5, "mode err");
      chk(bm_en, m == 2 || m >= 5, "bus master");
    end
    @(posedge clk) mode_data <= DQC_MODE_SW_POLL;
    pulse(4);
    @(posedge clk) {diff, ch_data} <= {1'b1, 4'hc};
    pulse(2);
    chk(ch_reg, DQC_CH_MAX_DIFF, "diff clip");
    @(posedge clk) {diff, ch_data} <= {1'b0, 4'h5};
    pulse(2);
    conv(5, 12'h9a7, 4'h5, 1'b0);
    dly <= 4'h6;
    conv(5, 12'h046, 4'h5, 1'b0);
    @(posedge clk) {auto, ch_data} <= {1'b1, 4'h2};
    pulse(2);
    for (int i = 0; i < 4; i++)
      conv(5, 12'(i), 4'((5 - i) % 3), 1'b0);
    @(posedge clk) ch_data <= 4'h3;
    pulse(2);
    conv(5, 12'h5e1, 4'h3, 1'b0);
    @(posedge clk) {auto, mode_data} <= {1'b0, DQC_MODE_EXT_IRQ};
    pulse(4);
    conv(7, 12'hb3d, 4'h3, 1'b1);
    @(posedge clk) mode_data <= DQC_MODE_TMR_IRQ;
    pulse(4);
    conv(6, 12'h7f0, 4'h3, 1'b1);
    @(posedge clk) mode_data <= DQC_MODE_TMR_BM;
    pulse(4);
    conv(6, 12'h2c4, 4'h3, 1'b0);
    @(posedge clk) mode_data <= DQC_MODE_EXT_BM;
    pulse(4);
    conv(7, 12'hd19, 4'h3, 1'b0);
    // Reset again mid-run: channel, range, mode and bus-master enable must fall back
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(ch_reg, DQC_CH_RST, "ch reset again");
    chk(range_o, DQC_RANGE_RST, "range reset again");
    chk(mode_o, DQC_MODE_RST, "mode reset again");
    chk(bm_en, 0, "bm reset");
    give_verdict();
  end
endmodule
`default_nettype wire

// File: dqc_dac_mem.sv
/*
  Two-word store for the D/A channel codes, with registered read data.
  Assumes writes and reads are on the same clock; index 0 is the first
  converter, index 1 the second.
*/
`default_nettype none
module dqc_dac_mem
  import dqc_pkg::*;
#(
  parameter int W = DQC_DAC_W
)(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic wr_en_in,
  input wire logic wr_sel_in,
  input wire logic [W-1:0] wr_data_in,
  output logic [W-1:0] first_out,
  output logic [W-1:0] second_out
);
  // Whole state of the store
  typedef struct packed {
    logic [1:0][W-1:0] word;
  } dqc_mem_st_t;
  dqc_mem_st_t st_r;
  dqc_mem_st_t st_nxt;

  // Write one word; the other keeps its code
  always_comb
  begin
    st_nxt = st_r;
    if (wr_en_in)
    begin
      st_nxt.word[wr_sel_in] = wr_data_in;
    end
  end

  // Register the store
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign first_out = st_r.word[0];
  assign second_out = st_r.word[1];
endmodule
`default_nettype wire

// File: dqc_pkg.sv
/*
  Package for the acquisition card control block: encodings, reset values,
  widths and the packed carriers shared by the top module and its memory.
  Assumes a single host clock domain; no bus, all controls are plain ports.
*/
`default_nettype none
package dqc_pkg;
  // Port widths
  localparam int DQC_DIO_W = 16;
  localparam int DQC_DAC_W = 12;
  localparam int DQC_CH_W = 4;
  localparam int DQC_RES_W = 16;
  // Result word field positions
  localparam int DQC_RES_CH_LSB = 0;
  localparam int DQC_RES_VAL_LSB = 4;
  // Channel limits per input wiring
  localparam logic [3:0] DQC_CH_MAX_SE = 4'hf;
  localparam logic [3:0] DQC_CH_MAX_DIFF = 4'h7;
  // Reset values
  localparam logic [3:0] DQC_CH_RST = 4'h0;
  localparam logic [15:0] DQC_DO_RST = 16'h0000;
  localparam logic [11:0] DQC_DAC_RST = 12'h000;
  // Gain codes
  typedef enum logic [2:0] {
    DQC_GAIN_HALF = 3'h0,
    DQC_GAIN_1 = 3'h1,
    DQC_GAIN_2 = 3'h2,
    DQC_GAIN_4 = 3'h3,
    DQC_GAIN_8 = 3'h4
  } dqc_gain_t;
  // Range setting: gain plus polarity (1 = unipolar)
  typedef struct packed {
    dqc_gain_t gain;
    logic unipolar;
  } dqc_range_t;
  localparam dqc_range_t DQC_RANGE_RST = '{gain: DQC_GAIN_1, unipolar: 1'b0};
  // Trigger and transfer mode codes 0..5
  localparam logic [2:0] DQC_MODE_SW_POLL = 3'h0;
  localparam logic [2:0] DQC_MODE_TMR_IRQ = 3'h1;
  localparam logic [2:0] DQC_MODE_TMR_BM = 3'h2;
  localparam logic [2:0] DQC_MODE_EXT_POLL = 3'h3;
  localparam logic [2:0] DQC_MODE_EXT_IRQ = 3'h4;
  localparam logic [2:0] DQC_MODE_EXT_BM = 3'h5;
  localparam logic [2:0] DQC_MODE_RST = DQC_MODE_SW_POLL;
  // Converter handshake states
  typedef enum logic [1:0] {DQC_IDLE, DQC_CONV} dqc_state_t;
  // Completed conversion as delivered to the host side
  typedef struct packed {
    logic [11:0] value;
    logic [3:0] chan;
  } dqc_result_t;
endpackage
`default_nettype wire
